/* File: hdl/cbi_pkg.sv */
/*
  Shared constants and types for the processor bus and interrupt controller.
  Assumes one system clock; every processor pin is asynchronous to it.
*/
package cbi_pkg;

  // ****************************************
  // Sequencing and vectors
  // ****************************************
  localparam logic [2:0] INIT_CYCLES = 3'h6;
  localparam logic [15:0] VEC_NMI_LO = 16'hFFFA;
  localparam logic [15:0] VEC_NMI_HI = 16'hFFFB;
  localparam logic [15:0] VEC_RST_LO = 16'hFFFC;
  localparam logic [15:0] VEC_RST_HI = 16'hFFFD;
  localparam logic [15:0] VEC_IRQ_HI = 16'hFFFF;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [7:0] STACK_PAGE = 8'h01;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam int unsigned P_BIT_V = 6;
  localparam int unsigned P_BIT_D = 3;
  localparam int unsigned P_BIT_I = 2;

  // ****************************************
  // Synchronised pin group
  // ****************************************
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned PIN_CLK = 5;
  localparam int unsigned PIN_IRQ = 4;
  localparam int unsigned PIN_NMI = 3;
  localparam int unsigned PIN_RDY = 2;
  localparam int unsigned PIN_SO = 1;
  localparam int unsigned PIN_RES = 0;
  localparam logic [5:0] PIN_INIT = 6'h1E;
  localparam logic [7:0] DATA_INIT = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    K_FETCH, K_OPERAND, K_READ, K_WRITE, K_ZP_PTR, K_ABS_PTR, K_JUMP
  } cbi_kind_t;

  typedef enum logic [3:0] {
    S_HOLD, S_INIT, S_VEC_LO, S_VEC_HI, S_IDLE, S_XFER, S_PTR_LO,
    S_PTR_HI, S_INT_DUMMY, S_PUSH_H, S_PUSH_L, S_PUSH_P
  } cbi_state_t;

  typedef struct packed {
    logic valid;
    cbi_kind_t kind;
    logic lock;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cbi_req_t;

  typedef struct packed {
    logic mask;
    logic decimal;
    logic overflow;
  } cbi_flags_t;

  typedef struct packed {
    logic done;
    logic fetch;
    logic [7:0] data;
    logic [15:0] eff_addr;
  } cbi_rsp_t;

  localparam cbi_flags_t FLAGS_RESET = '{mask: 1'h1, decimal: 1'h0, overflow: 1'h0};

endpackage : cbi_pkg

/* File: hdl/cbi_pin_sync.sv */
/*
  Three-stage synchroniser for a group of asynchronous pins.
  A bit's level is accepted only once stages two and three agree.
*/
`timescale 1ns/100ps
module cbi_pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Pins and filtered levels
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      o_level <= INIT;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      // Disagreeing stages keep the old level
      o_level <= (s2 & s3) | (o_level & (s2 ^ s3));
    end
  end

endmodule : cbi_pin_sync

/* File: hdl/cbi_bus_ctrl.sv */
/*
  Bus, control and interrupt sequencer of an 8-bit processor.
  Assumes the instruction core sits on the same clock and issues one
  request per bus cycle; memory and I/O sit on the far side of the pins.
*/
// Contract
// RL1: Page-zero pointer mode reads effective address low then high from page zero.
// RL2: Absolute pointer mode reads target low/high at pointer and loads program counter.
// RL3: A 16-bit address is driven for every memory and I/O transfer.
// RL4: Two output clocks: phase two follows clock_in, phase one is inverted.
// RL5: Data bus is bidirectional and released whenever the device is not writing.
// RL6: Unmasked maskable request sampled in phase two starts stacking after instruction.
// RL7: Maskable vector high byte sits at FFFF; control moves to its address.
// RL8: Maskable vector low byte is read just below the high byte.
// RL9: No interrupt is recognised while ready_hold is low.
// RL10: bus_lock_n is low during read-modify-write modify and write cycles.
// RL11: Non-maskable falling edge sampled in phase two vectors through FFFA/FFFB.
// RL12: Non-maskable requests are never masked, even during an earlier service.
// RL13: ready_hold low in phase one halts with the current address held.
// RL14: The ready_hold halt applies to every cycle type, writes included.
// RL15: The outside holds reset low at least two cycles; rising edge starts initialisation.
// RL16: Six initialisation cycles, then set mask, clear decimal, vector FFFC/FFFD.
// RL17: read_not_write is high on reads, low only with valid write data.
// RL18: Falling overflow_set_n, sampled at end of phase one, sets overflow.
// RL19: opcode_fetch_marker is high for the whole opcode fetch cycle only.
// RL20: ready_hold low in a fetch's phase one freezes state until it rises.
`timescale 1ns/100ps
module cbi_bus_ctrl
  import cbi_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Processor input pins
  input wire logic i_clock_in,
  input wire logic i_maskable_request_n,
  input wire logic i_nonmaskable_request_n,
  input wire logic i_ready_hold,
  input wire logic i_overflow_set_n,
  input wire logic i_reset_in_n,
  input wire logic [7:0] i_data_lines,
  // Processor output pins
  output logic [15:0] o_address_lines,
  output logic [7:0] o_data_lines,
  output logic o_data_lines_oe,
  output logic o_read_not_write,
  output logic o_opcode_fetch_marker,
  output logic o_bus_lock_n,
  output logic o_clock_phase_one_out,
  output logic o_clock_phase_two_out,
  // Core requests
  input wire cbi_req_t i_req,
  input wire logic i_flags_we,
  input wire cbi_flags_t i_flags,
  input wire logic [7:0] i_status_byte,
  input wire logic i_sp_we,
  input wire logic [7:0] i_sp,
  // Core answers and state
  output logic o_req_taken,
  output cbi_rsp_t o_rsp,
  output cbi_flags_t o_flags,
  output logic [15:0] o_pc,
  output logic [7:0] o_sp,
  output logic o_halted
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [PIN_COUNT-1:0] pins_s;
  logic [7:0] din;
  logic clk_s;
  logic irq_n_s;
  logic nmi_n_s;
  logic rdy_s;
  logic so_n_s;
  logic res_n_s;

  cbi_pin_sync #(.W(PIN_COUNT), .INIT(PIN_INIT)) u_pin_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_pin({i_clock_in, i_maskable_request_n, i_nonmaskable_request_n,
            i_ready_hold, i_overflow_set_n, i_reset_in_n}),
    .o_level(pins_s)
  );

  // Data rides the same delay as clock_in, so capture lines up with the phase
  cbi_pin_sync #(.W(8), .INIT(DATA_INIT)) u_data_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_pin(i_data_lines),
    .o_level(din)
  );

  assign clk_s = pins_s[PIN_CLK];
  assign irq_n_s = pins_s[PIN_IRQ];
  assign nmi_n_s = pins_s[PIN_NMI];
  assign rdy_s = pins_s[PIN_RDY];
  assign so_n_s = pins_s[PIN_SO];
  assign res_n_s = pins_s[PIN_RES];

  // ****************************************
  // Phase tracking
  // ****************************************
  logic clk_d;
  logic ph1_start;
  logic ph2_start;
  logic rdy_ph1;
  logic advance;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_d <= 1'h0;
    end else begin
      clk_d <= clk_s;
    end
  end

  assign ph1_start = clk_d & ~clk_s;
  assign ph2_start = ~clk_d & clk_s;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_clock_phase_two_out <= 1'h0;
      o_clock_phase_one_out <= 1'h1;
    end else begin
      o_clock_phase_two_out <= clk_s; // RL4
      o_clock_phase_one_out <= ~clk_s; // RL4
    end
  end

  // Ready seen at the end of phase one decides the halt
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdy_ph1 <= 1'h1;
    end else if (ph2_start) begin
      rdy_ph1 <= rdy_s; // RL13
    end
  end

  // A cycle ends only if ready was high in both phases; otherwise it repeats
  assign advance = ph1_start & rdy_ph1 & rdy_s & res_n_s; // RL13 RL14 RL20

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_halted <= 1'h0;
    end else if (ph1_start) begin
      o_halted <= ~(rdy_ph1 & rdy_s);
    end
  end

  // ****************************************
  // Interrupt and overflow inputs
  // ****************************************
  cbi_state_t state;
  cbi_state_t next_state;
  logic nmi_prev;
  logic nmi_pend;
  logic nmi_set;
  logic next_nmi_clr;
  logic irq_take;
  logic so_prev;
  logic so_fall;

  // Edges seen while ready is low are not recognised
  assign nmi_set = ph1_start & rdy_s & nmi_prev & ~nmi_n_s; // RL9 RL11

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      nmi_prev <= 1'h1;
      nmi_pend <= 1'h0;
    end else begin
      // Tracking through a halt lets an edge under low ready pass unseen
      if (ph1_start) begin
        nmi_prev <= nmi_n_s;
      end
      // A new edge during service is kept; set beats clear
      nmi_pend <= nmi_set | (nmi_pend & ~(advance & next_nmi_clr)); // RL12
    end
  end

  // The mask is only being set as the vector read ends, so block re-entry there
  assign irq_take = ~irq_n_s & ~o_flags.mask & rdy_s & (state != S_VEC_HI); // RL6 RL9

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      so_prev <= 1'h1;
    end else if (ph2_start) begin
      so_prev <= so_n_s; // RL18
    end
  end

  assign so_fall = ph2_start & so_prev & ~so_n_s; // RL18

  // ****************************************
  // Cycle sequencer
  // ****************************************
  cbi_kind_t cur_kind;
  cbi_kind_t next_kind;
  logic [15:0] vec_hi;
  logic [15:0] next_vec;
  logic [15:0] next_addr;
  logic [15:0] next_pc;
  logic [7:0] next_sp;
  logic [7:0] next_wdata;
  logic [7:0] tmp;
  logic [7:0] next_tmp;
  logic [7:0] pbyte;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic next_rnw;
  logic next_sync;
  logic next_lock_n;
  logic next_take;
  logic start_new;

  always_comb begin
    next_state = state;
    next_kind = cur_kind;
    next_vec = vec_hi;
    next_addr = o_address_lines;
    next_pc = o_pc;
    next_sp = o_sp;
    next_wdata = o_data_lines;
    next_tmp = tmp;
    next_cnt = cnt;
    next_rnw = o_read_not_write;
    next_sync = o_opcode_fetch_marker;
    next_lock_n = o_bus_lock_n;
    next_take = 1'h0;
    next_nmi_clr = 1'h0;
    start_new = 1'h0;
    pbyte = i_status_byte;
    pbyte[P_BIT_V] = o_flags.overflow;
    pbyte[P_BIT_D] = o_flags.decimal;
    pbyte[P_BIT_I] = o_flags.mask;
    unique case (state)
      S_HOLD: begin
        next_state = S_INIT;
        next_cnt = 3'h0;
        next_addr = {STACK_PAGE, o_sp};
      end
      S_INIT: begin
        if (cnt == INIT_CYCLES - 3'h1) begin // RL16
          next_state = S_VEC_LO;
          next_vec = VEC_RST_HI;
          next_addr = VEC_RST_LO; // RL16
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end
      S_VEC_LO: begin
        next_tmp = din;
        next_addr = vec_hi; // RL7
        next_state = S_VEC_HI;
      end
      S_VEC_HI: begin
        next_pc = {din, tmp}; // RL7 RL11 RL16
        start_new = 1'h1;
      end
      S_IDLE: begin
        start_new = 1'h1;
      end
      S_XFER: begin
        if (cur_kind == K_FETCH || cur_kind == K_OPERAND) begin
          next_pc = o_pc + 16'h0001;
        end
        start_new = 1'h1;
      end
      S_PTR_LO: begin
        next_tmp = din;
        if (cur_kind == K_ZP_PTR) begin
          next_addr = {ZERO_PAGE, o_address_lines[7:0] + 8'h01}; // RL1
        end else begin
          next_addr = o_address_lines + 16'h0001; // RL2
        end
        next_state = S_PTR_HI;
      end
      S_PTR_HI: begin
        if (cur_kind == K_ABS_PTR) begin
          next_pc = {din, tmp}; // RL2
        end
        start_new = 1'h1;
      end
      S_INT_DUMMY: begin
        next_addr = {STACK_PAGE, o_sp}; // RL6
        next_rnw = 1'h0;
        next_wdata = o_pc[15:8];
        next_state = S_PUSH_H;
      end
      S_PUSH_H: begin
        next_sp = o_sp - 8'h01;
        next_addr = {STACK_PAGE, next_sp};
        next_wdata = o_pc[7:0];
        next_state = S_PUSH_L;
      end
      S_PUSH_L: begin
        next_sp = o_sp - 8'h01;
        next_addr = {STACK_PAGE, next_sp};
        next_wdata = pbyte;
        next_state = S_PUSH_P;
      end
      S_PUSH_P: begin
        next_sp = o_sp - 8'h01;
        next_rnw = 1'h1;
        next_addr = vec_hi - 16'h0001; // RL8
        next_state = S_VEC_LO;
      end
      default: begin
        next_state = S_HOLD;
      end
    endcase
    // Interrupts are taken only where the next instruction would start
    if (start_new) begin
      next_rnw = 1'h1;
      next_sync = 1'h0;
      next_lock_n = 1'h1;
      next_state = S_IDLE;
      next_addr = next_pc;
      if (i_req.valid && i_req.kind == K_FETCH && (nmi_pend || irq_take)) begin
        next_state = S_INT_DUMMY; // RL6 RL11
        next_vec = nmi_pend ? VEC_NMI_HI : VEC_IRQ_HI; // RL7 RL11
        next_nmi_clr = nmi_pend;
      end else if (i_req.valid) begin
        next_take = 1'h1;
        next_kind = i_req.kind;
        next_state = S_XFER;
        unique case (i_req.kind)
          K_FETCH: begin
            next_sync = 1'h1; // RL19
          end
          K_OPERAND: begin
            next_sync = 1'h0;
          end
          K_READ: begin
            next_addr = i_req.addr; // RL3
            next_lock_n = ~i_req.lock; // RL10
          end
          K_WRITE: begin
            next_addr = i_req.addr; // RL3
            next_rnw = 1'h0; // RL17
            next_wdata = i_req.wdata;
            next_lock_n = ~i_req.lock; // RL10
          end
          K_ZP_PTR: begin
            next_addr = {ZERO_PAGE, i_req.addr[7:0]}; // RL1
            next_state = S_PTR_LO;
          end
          K_ABS_PTR: begin
            next_addr = i_req.addr; // RL2
            next_state = S_PTR_LO;
          end
          K_JUMP: begin
            next_pc = i_req.addr;
            next_addr = i_req.addr;
            next_state = S_IDLE;
          end
          default: begin
            next_take = 1'h0;
            next_state = S_IDLE;
          end
        endcase
      end
    end
  end

  // A low reset pin holds the sequencer in S_HOLD; its release starts initialisation
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_HOLD;
      cur_kind <= K_FETCH;
      vec_hi <= VEC_RST_HI;
      o_address_lines <= PC_RESET;
      o_pc <= PC_RESET;
      o_data_lines <= DATA_INIT;
      tmp <= DATA_INIT;
      cnt <= 3'h0;
      o_read_not_write <= 1'h1;
      o_opcode_fetch_marker <= 1'h0;
      o_bus_lock_n <= 1'h1;
    end else if (!res_n_s) begin
      state <= S_HOLD; // RL15 RL16
      o_read_not_write <= 1'h1;
      o_opcode_fetch_marker <= 1'h0;
      o_bus_lock_n <= 1'h1;
    end else if (advance) begin
      state <= next_state;
      cur_kind <= next_kind;
      vec_hi <= next_vec;
      o_address_lines <= next_addr; // RL3 RL13
      o_pc <= next_pc;
      o_data_lines <= next_wdata;
      tmp <= next_tmp;
      cnt <= next_cnt;
      o_read_not_write <= next_rnw; // RL17
      o_opcode_fetch_marker <= next_sync; // RL19
      o_bus_lock_n <= next_lock_n; // RL10
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sp <= SP_RESET;
    end else if (advance) begin
      o_sp <= next_sp;
    end else if (i_sp_we) begin
      o_sp <= i_sp;
    end
  end

  // Write data is driven only in phase two of a write cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data_lines_oe <= 1'h0;
    end else begin
      o_data_lines_oe <= ~o_read_not_write & clk_s & res_n_s; // RL5 RL17
    end
  end

  // ****************************************
  // Core answers and status flags
  // ****************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req_taken <= 1'h0;
      o_rsp <= '0;
    end else begin
      o_req_taken <= advance & next_take;
      o_rsp.done <= advance & (state == S_XFER || state == S_PTR_HI);
      if (advance) begin
        o_rsp.fetch <= cur_kind == K_FETCH;
        o_rsp.data <= din;
        o_rsp.eff_addr <= {din, tmp}; // RL1
      end
    end
  end

  // Hardware sets win over a core write in the same cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flags <= FLAGS_RESET;
    end else begin
      if (i_flags_we) begin
        o_flags <= i_flags;
      end
      if (advance && state == S_VEC_HI) begin
        o_flags.mask <= 1'h1; // RL6 RL16
        if (vec_hi == VEC_RST_HI) begin
          o_flags.decimal <= 1'h0; // RL16
        end
      end
      if (so_fall) begin
        o_flags.overflow <= 1'h1; // RL18
      end
    end
  end

endmodule : cbi_bus_ctrl

/* File: test/cbi_bus_ctrl_assertions.sv */
/*
  Concurrent checks on the pins and flags of the bus controller.
  Assumes one clock domain; bound to cbi_bus_ctrl, sees only its ports.
*/
`timescale 1ns/100ps
module cbi_bus_ctrl_checker
  import cbi_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Watched inputs
  input wire logic i_clock_in,
  input wire logic i_flags_we,
  // Watched outputs
  input wire logic [15:0] o_address_lines,
  input wire logic o_data_lines_oe,
  input wire logic o_read_not_write,
  input wire logic o_opcode_fetch_marker,
  input wire logic o_bus_lock_n,
  input wire logic o_clock_phase_one_out,
  input wire logic o_clock_phase_two_out,
  input wire cbi_flags_t o_flags,
  input wire logic [15:0] o_pc,
  input wire logic o_halted
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  // ********************
  // Clock outputs
  // ********************
  clk_follow_a: assert property (
    $stable(i_clock_in) [*6] |-> o_clock_phase_two_out == i_clock_in)
    else $error("phase two output does not follow the clock pin");
  clk_invert_a: assert property (
    o_clock_phase_one_out != o_clock_phase_two_out)
    else $error("phase one output is not the inverse of phase two");

  // ********************
  // Bus cycle
  // ********************
  oe_write_a: assert property (
    o_data_lines_oe |-> !o_read_not_write)
    else $error("data bus driven outside a write cycle");
  marker_read_a: assert property (
    o_opcode_fetch_marker |-> o_read_not_write && !o_data_lines_oe)
    else $error("fetch marker high in a write cycle");
  marker_held_a: assert property (
    $rose(o_opcode_fetch_marker) |-> o_opcode_fetch_marker [*8])
    else $error("fetch marker dropped early");
  addr_steady_a: assert property (
    $rose(o_clock_phase_two_out) |-> ##1 $stable(o_address_lines) [*4])
    else $error("address moved in phase two");
  halt_freeze_a: assert property (
    o_halted && $past(o_halted) |-> $stable(o_address_lines) && $stable(o_pc))
    else $error("state moved while halted");
  lock_fetch_a: assert property (
    !o_bus_lock_n |-> !o_opcode_fetch_marker)
    else $error("bus lock asserted on an opcode fetch");
  ovf_clear_a: assert property (
    $fell(o_flags.overflow) |-> $past(i_flags_we))
    else $error("overflow cleared without a flag write");
endmodule : cbi_bus_ctrl_checker

bind cbi_bus_ctrl cbi_bus_ctrl_checker cbi_bus_ctrl_checker_inst (
  .i_clock(i_clock),
  .i_resetn(i_resetn),
  .i_clock_in(i_clock_in),
  .i_flags_we(i_flags_we),
  .o_address_lines(o_address_lines),
  .o_data_lines_oe(o_data_lines_oe),
  .o_read_not_write(o_read_not_write),
  .o_opcode_fetch_marker(o_opcode_fetch_marker),
  .o_bus_lock_n(o_bus_lock_n),
  .o_clock_phase_one_out(o_clock_phase_one_out),
  .o_clock_phase_two_out(o_clock_phase_two_out),
  .o_flags(o_flags),
  .o_pc(o_pc),
  .o_halted(o_halted)
);

/* File: test/cbi_mem_model.sv */
/*
  Behavioural memory on the processor pins; resolves the shared data bus.
  Assumes reads are taken late in the cycle, so one clock of lag is harmless.
*/
`timescale 1ns/100ps
module cbi_mem_model (
  // Clock
  input wire logic i_clock,
  // Processor pins
  input wire logic [15:0] i_address_lines,
  input wire logic i_read_not_write,
  input wire logic [7:0] i_data_lines,
  input wire logic i_data_lines_oe,
  // Resolved data bus level
  output logic [7:0] o_data_bus
);
  logic [7:0] mem [logic [15:0]];

  function automatic logic [7:0] fill(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction : fill

  initial begin
    o_data_bus = 8'h00;
  end

  // Undriven write window toggles so stale data is never mistaken for a value
  always @(posedge i_clock) begin
    if (i_data_lines_oe) begin
      o_data_bus <= i_data_lines;
      if (!i_read_not_write) begin
        mem[i_address_lines] = i_data_lines;
      end
    end else if (i_read_not_write) begin
      o_data_bus <= mem.exists(i_address_lines) ? mem[i_address_lines] : fill(i_address_lines);
    end else begin
      o_data_bus <= ~o_data_bus;
    end
  end
endmodule : cbi_mem_model

/* File: test/cbi_bus_ctrl_tb.sv */
/*
  Self-checking bench: core requests, pin events and a memory model.
  Assumes the processor clock pin runs about 16 system clocks a period.
*/
`timescale 1ns/100ps
module cbi_bus_ctrl_tb;
  import cbi_pkg::*;

  logic clock, resetn, pin_clk, irq_n, nmi_n, ready, so_n, res_n, flags_we;
  logic oe, rnw, marker, lock_n, halted, taken;
  logic [7:0] bus, wdata, sp_out, sp, d;
  logic [15:0] addr, pc_out, pc, a, v;
  cbi_req_t req;
  cbi_rsp_t rsp;
  cbi_flags_t flags, flg;
  int seed, fail_count, n_checks;
  logic [7:0] shadow [logic [15:0]];

  // ********************
  // Instances and clocks
  // ********************
  cbi_bus_ctrl cbi_bus_ctrl_inst (.i_clock(clock), .i_resetn(resetn), .i_clock_in(pin_clk),
    .i_maskable_request_n(irq_n), .i_nonmaskable_request_n(nmi_n), .i_ready_hold(ready),
    .i_overflow_set_n(so_n), .i_reset_in_n(res_n), .i_data_lines(bus),
    .o_address_lines(addr), .o_data_lines(wdata), .o_data_lines_oe(oe),
    .o_read_not_write(rnw), .o_opcode_fetch_marker(marker), .o_bus_lock_n(lock_n),
    .o_clock_phase_one_out(), .o_clock_phase_two_out(), .i_req(req), .i_flags_we(flags_we),
    .i_flags(flags), .i_status_byte(8'h00), .i_sp_we(1'b0), .i_sp(8'h00),
    .o_req_taken(taken), .o_rsp(rsp), .o_flags(flg), .o_pc(pc_out), .o_sp(sp_out),
    .o_halted(halted));
  cbi_mem_model cbi_mem_model_inst (.i_clock(clock), .i_address_lines(addr),
    .i_read_not_write(rnw), .i_data_lines(wdata), .i_data_lines_oe(oe), .o_data_bus(bus));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    pin_clk = 1'b0;
    forever begin
      repeat (8) @(posedge clock);
      pin_clk <= ~pin_clk;
    end
  end

  // ********************
  // Tasks
  // ********************
  function automatic logic [7:0] mb(input logic [15:0] x);
    if (shadow.exists(x)) return shadow[x];
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction : mb

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic wait_on(input logic want_done);
    int n;
    n = 0;
    while ((want_done ? rsp.done : taken) !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 900) begin
        chk(16'h0, 16'h1);
        end_of_test();
      end
    end
  endtask : wait_on

  // Optional stall holds ready low across the cycle just taken
  task automatic op(input cbi_kind_t k, input logic [15:0] ad, input logic [7:0] wd,
                    input logic lk, input logic stall);
    @(posedge clock);
    req <= '{valid: 1'b1, kind: k, lock: lk, addr: ad, wdata: wd};
    wait_on(1'b0);
    chk(rnw, k != K_WRITE);
    chk(marker, k == K_FETCH);
    chk(lock_n, !lk);
    @(posedge clock);
    req <= '0;
    if (stall) begin
      ready <= 1'b0;
      repeat (70) @(posedge clock);
      #1;
      chk(halted, 1'b1);
      chk(addr, ad);
      @(posedge clock);
      ready <= 1'b1;
    end
    wait_on(1'b1);
  endtask : op

  // ********************
  // Scenarios
  // ********************
  initial begin
    seed = 32'hda0e;
    fail_count = 0;
    n_checks = 0;
    resetn = 1'b0;
    res_n = 1'b0;
    irq_n = 1'b1;
    nmi_n = 1'b1;
    ready = 1'b1;
    so_n = 1'b1;
    flags_we = 1'b0;
    flags = '0;
    req = '0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (50) @(posedge clock);
    res_n <= 1'b1;
    repeat (300) @(posedge clock);
    #1;
    pc = {mb(VEC_RST_HI), mb(VEC_RST_LO)};
    sp = SP_RESET;
    chk(pc_out, pc);
    chk({13'h0, flg}, 16'h4);
    $display("%0t: reset done", $time);
    for (int i = 0; i < 3; i++) begin
      op(i == 2 ? K_OPERAND : K_FETCH, pc, 8'h00, 1'b0, i == 1);
      chk(rsp.data, mb(pc));
      pc = pc + 16'h1;
      chk(pc_out, pc);
    end
    $display("%0t: fetch done", $time);
    for (int i = 0; i < 6; i++) begin
      a = {3'h1, 13'($random(seed))};
      d = 8'($random(seed));
      op(K_WRITE, a, d, i[0], i == 2);
      shadow[a] = d;
      op(K_READ, a, 8'h00, 1'b0, i == 3);
      chk(rsp.data, d);
    end
    $display("%0t: read write done", $time);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'hFF : 8'($random(seed));
      op(K_ZP_PTR, {8'h00, d}, 8'h00, 1'b0, 1'b0);
      chk(rsp.eff_addr, {mb({ZERO_PAGE, d + 8'h1}), mb({ZERO_PAGE, d})});
    end
    a = 16'h30FF;
    op(K_ABS_PTR, a, 8'h00, 1'b0, 1'b0);
    pc = {mb(a + 16'h1), mb(a)};
    chk(rsp.eff_addr, pc);
    chk(pc_out, pc);
    a = 16'($random(seed));
    @(posedge clock);
    req <= '{valid: 1'b1, kind: K_JUMP, lock: 1'b0, addr: a, wdata: 8'h00};
    wait_on(1'b0);
    @(posedge clock);
    req <= '0;
    pc = a;
    chk(addr, pc);
    chk(pc_out, pc);
    $display("%0t: pointer done", $time);
    chk(flg.overflow, 1'b0);
    @(posedge clock);
    so_n <= 1'b0;
    repeat (40) @(posedge clock);
    so_n <= 1'b1;
    repeat (40) @(posedge clock);
    #1;
    chk(flg.overflow, 1'b1);
    @(posedge clock);
    ready <= 1'b0;
    nmi_n <= 1'b0;
    repeat (60) @(posedge clock);
    ready <= 1'b1;
    repeat (40) @(posedge clock);
    op(K_FETCH, pc, 8'h00, 1'b0, 1'b0);
    chk(rsp.data, mb(pc));
    pc = pc + 16'h1;
    @(posedge clock);
    nmi_n <= 1'b1;
    repeat (30) @(posedge clock);
    nmi_n <= 1'b0;
    repeat (40) @(posedge clock);
    op(K_FETCH, pc, 8'h00, 1'b0, 1'b0);
    v = {mb(VEC_NMI_HI), mb(VEC_NMI_LO)};
    chk(rsp.data, mb(v));
    shadow[{STACK_PAGE, sp}] = pc[15:8];
    shadow[{STACK_PAGE, sp - 8'h1}] = pc[7:0];
    shadow[{STACK_PAGE, sp - 8'h2}] = 8'h44;
    sp = sp - 8'h3;
    pc = v + 16'h1;
    chk(pc_out, pc);
    chk(sp_out, sp);
    @(posedge clock);
    nmi_n <= 1'b1;
    for (int j = 1; j < 4; j++) begin
      op(K_READ, {STACK_PAGE, sp + 8'(j)}, 8'h00, 1'b0, 1'b0);
      chk(rsp.data, mb({STACK_PAGE, sp + 8'(j)}));
    end
    $display("%0t: non-maskable done", $time);
    @(posedge clock);
    flags_we <= 1'b1;
    flags <= '{mask: 1'b0, decimal: 1'b0, overflow: 1'b0};
    @(posedge clock);
    flags_we <= 1'b0;
    irq_n <= 1'b0;
    repeat (40) @(posedge clock);
    op(K_FETCH, pc, 8'h00, 1'b0, 1'b0);
    v = {mb(VEC_IRQ_HI), mb(VEC_IRQ_HI - 16'h1)};
    chk(rsp.data, mb(v));
    chk(pc_out, v + 16'h1);
    chk(flg.mask, 1'b1);
    sp = sp - 8'h3;
    chk(sp_out, sp);
    @(posedge clock);
    irq_n <= 1'b1;
    $display("%0t: maskable done", $time);
    end_of_test();
  end
endmodule : cbi_bus_ctrl_tb
